//--- distance_measure_sequencer.sv
// How it works
// - Emitter power set only by pulse width.
// - Width capped 320/240/160/80/40us, default 320us.
// - Smaller cap keeps slot timing unchanged.
// - Sum N pulse signals before spot computation.
// - N is 1, 5, 10 or 30, default 10.
// - Median window 5, 7, 9; 1 bypasses.
// - Output after first measurement, early ones indefinite.
// - Full window gives sliding median every measurement.
// - Response time follows window and N.
// - Default: no filter, N of 10.
`timescale 1ns/100ps
module distance_measure_sequencer #(
   parameter int SLOT_US = dms_pkg::SLOT_US,
   parameter int SW      = 16,
   parameter int DW      = 10,
   parameter int LOW_TH  = 16'h1000,
   parameter int HIGH_TH = 16'hC000
) (
   input  wire logic          mclk_i,
   input  wire logic          arst_n_i,
   input  wire logic [2:0]    cap_sel_i,
   input  wire logic [1:0]    accum_sel_i,
   input  wire logic [1:0]    median_sel_i,
   input  wire logic          det_valid_i,
   input  wire logic [SW-1:0] det_sample_i,
   input  wire logic          dist_valid_i,
   input  wire logic [DW-1:0] dist_i,
   output logic               emitter_on_o,
   output logic               acc_valid_o,
   output logic [SW+4:0]      acc_sum_o,
   output logic               dist_valid_o,
   output logic [DW-1:0]      dist_o,
   output logic               dist_definite_o
);
   localparam int CW  = dms_pkg::CAP_W;
   localparam int SLW = $clog2(SLOT_US + 1);
   localparam logic [SLW-1:0] SLOT_LAST = SLW'(SLOT_US - 1);
   localparam logic [4:0] TICK_LAST = 5'(dms_pkg::US_CYC - 1);

   logic [4:0]     tick_cnt_r;
   logic           us_tick;
   logic [SLW-1:0] slot_us_r;
   logic           slot_end;
   logic [2:0]     cap_sel_r;
   logic [1:0]     acc_sel_r;
   logic [1:0]     med_sel_r;
   logic [CW-1:0]  cap_us;
   logic [CW-1:0]  width_r;
   logic [CW-1:0]  on_width_r;
   logic           emitter_on_r;
   logic [4:0]     acc_n;
   logic [4:0]     pcnt_r;
   logic [SW+4:0]  sum_r;
   logic           meas_end;

   med_if #(.DW(DW)) mif ();

   ////////////////////////////////////////////////////////////////////////
   // One-microsecond enable and the fixed pulse slot. The slot never
   // depends on the width, so a lower cap only shortens the on time.
   assign us_tick  = (tick_cnt_r == TICK_LAST);
   assign slot_end = us_tick && (slot_us_r == SLOT_LAST);

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_cnt_r <= 5'h0;
      end else begin
         tick_cnt_r <= us_tick ? 5'h0 : tick_cnt_r + 5'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         slot_us_r <= '0;
      end else if (us_tick) begin
         slot_us_r <= slot_end ? '0 : slot_us_r + SLW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Settings are taken at boundaries: the cap at each slot, the count
   // and window only between measurements, so no sum mixes two counts.
   assign meas_end = det_valid_i && (pcnt_r >= acc_n - 5'h1);

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cap_sel_r <= dms_pkg::CAP_SEL_RST;
         acc_sel_r <= dms_pkg::ACC_SEL_RST;
         med_sel_r <= dms_pkg::MED_SEL_RST;
      end else begin
         if (slot_end) begin
            cap_sel_r <= cap_sel_i;
         end
         if (meas_end || (pcnt_r == 5'h0 && !det_valid_i)) begin
            acc_sel_r <= accum_sel_i;
            med_sel_r <= median_sel_i;
         end
      end
   end

   always_comb begin
      unique case (cap_sel_r)
         3'h1:    cap_us = dms_pkg::CAP1_US;
         3'h2:    cap_us = dms_pkg::CAP2_US;
         3'h3:    cap_us = dms_pkg::CAP3_US;
         3'h4:    cap_us = dms_pkg::CAP4_US;
         default: cap_us = dms_pkg::CAP0_US;
      endcase
   end

   always_comb begin
      unique case (dms_pkg::acc_sel_e'(acc_sel_r))
         dms_pkg::ACC_1:  acc_n = 5'd1;
         dms_pkg::ACC_5:  acc_n = 5'd5;
         dms_pkg::ACC_30: acc_n = 5'd30;
         dms_pkg::ACC_10: acc_n = 5'd10;
      endcase
   end

   always_comb begin
      unique case (dms_pkg::med_sel_e'(med_sel_r))
         dms_pkg::MED_5: mif.win_n = 4'd5;
         dms_pkg::MED_7: mif.win_n = 4'd7;
         dms_pkg::MED_9: mif.win_n = 4'd9;
         dms_pkg::MED_1: mif.win_n = 4'd1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Power loop: a weak return widens the pulse, a strong one narrows it.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         width_r <= dms_pkg::CAP0_US;
      end else if (width_r > cap_us) begin
         width_r <= cap_us;
      end else if (det_valid_i) begin
         if (32'(det_sample_i) < LOW_TH) begin
            if (cap_us - width_r > dms_pkg::WIDTH_STEP_US) begin
               width_r <= width_r + dms_pkg::WIDTH_STEP_US;
            end else begin
               width_r <= cap_us;
            end
         end else if (32'(det_sample_i) > HIGH_TH) begin
            if (width_r > dms_pkg::WIDTH_MIN_US + dms_pkg::WIDTH_STEP_US) begin
               width_r <= width_r - dms_pkg::WIDTH_STEP_US;
            end else begin
               width_r <= dms_pkg::WIDTH_MIN_US;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         on_width_r   <= '0;
         emitter_on_r <= 1'b0;
      end else if (us_tick) begin
         if (slot_end) begin
            on_width_r   <= (width_r > cap_us) ? cap_us : width_r;
            emitter_on_r <= 1'b1;
         end else if (SLW'(on_width_r) <= slot_us_r + SLW'(1)) begin
            emitter_on_r <= 1'b0;
         end
      end
   end
   assign emitter_on_o = emitter_on_r;

   ////////////////////////////////////////////////////////////////////////
   // Pulse accumulation ahead of spot computation.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pcnt_r      <= 5'h0;
         sum_r       <= '0;
         acc_sum_o   <= '0;
         acc_valid_o <= 1'b0;
      end else begin
         acc_valid_o <= meas_end;
         if (meas_end) begin
            acc_sum_o <= sum_r + (SW+5)'(det_sample_i);
            sum_r     <= '0;
            pcnt_r    <= 5'h0;
         end else if (det_valid_i) begin
            sum_r  <= sum_r + (SW+5)'(det_sample_i);
            pcnt_r <= pcnt_r + 5'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response time is the window length in measurements plus the
   // compute latency, so it scales with both settings.
   assign mif.in_valid = dist_valid_i;
   assign mif.in_data  = dist_i;

   median_stage #(.DW(DW)) u_median (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .mif      (mif)
   );

   assign dist_valid_o    = mif.out_valid;
   assign dist_o          = mif.out_data;
   assign dist_definite_o = mif.out_definite;

   cap_limit_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      emitter_on_r |-> on_width_r <= dms_pkg::CAP0_US &&
      slot_us_r <= SLW'(on_width_r)) else $error("pulse over cap");
   width_up_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (det_valid_i && 32'(det_sample_i) < LOW_TH &&
       width_r + dms_pkg::WIDTH_STEP_US < cap_us) |=>
      width_r == $past(width_r) + dms_pkg::WIDTH_STEP_US)
      else $error("width not raised");
   slot_fixed_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $rose(emitter_on_r) |-> $past(slot_end))
      else $error("pulse off slot");
   accum_count_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      det_valid_i && pcnt_r == acc_n - 5'h1 |=> acc_valid_o && pcnt_r == 5'h0)
      else $error("accumulation count wrong");
   sum_value_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      meas_end |=> acc_sum_o == $past(sum_r) + (SW+5)'($past(det_sample_i)))
      else $error("sum wrong");
endmodule

//--- dms_pkg.sv
package dms_pkg;
   localparam int CLK_NS  = 50;
   localparam int TICK_NS = 1000;
   localparam int US_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLOT_US = 1900;
   localparam int CAP_W   = 9;
   localparam logic [CAP_W-1:0] CAP0_US = 9'd320;
   localparam logic [CAP_W-1:0] CAP1_US = 9'd240;
   localparam logic [CAP_W-1:0] CAP2_US = 9'd160;
   localparam logic [CAP_W-1:0] CAP3_US = 9'd80;
   localparam logic [CAP_W-1:0] CAP4_US = 9'd40;
   localparam logic [CAP_W-1:0] WIDTH_MIN_US = 9'd10;
   localparam logic [CAP_W-1:0] WIDTH_STEP_US = 9'd10;
   localparam logic [2:0] CAP_SEL_RST = 3'h0;
   localparam logic [1:0] ACC_SEL_RST = 2'h0;
   localparam logic [1:0] MED_SEL_RST = 2'h0;
   localparam int WIN_MAX = 9;
   typedef enum logic [1:0] {
      ACC_10 = 2'h0,
      ACC_1  = 2'h1,
      ACC_5  = 2'h2,
      ACC_30 = 2'h3
   } acc_sel_e;
   typedef enum logic [1:0] {
      MED_1 = 2'h0,
      MED_5 = 2'h1,
      MED_7 = 2'h2,
      MED_9 = 2'h3
   } med_sel_e;
endpackage

//--- med_if.sv
`timescale 1ns/100ps
interface med_if #(parameter int DW = 10);
   logic          in_valid;
   logic [DW-1:0] in_data;
   logic [3:0]    win_n;
   logic          out_valid;
   logic [DW-1:0] out_data;
   logic          out_definite;
   modport seq  (output in_valid, in_data, win_n,
                 input  out_valid, out_data, out_definite);
   modport filt (input  in_valid, in_data, win_n,
                 output out_valid, out_data, out_definite);
endinterface

//--- median_stage.sv
`timescale 1ns/100ps
module median_stage #(
   parameter int DW = 10
) (
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   med_if.filt       mif
);
   localparam int WM = dms_pkg::WIN_MAX;
   // The newest result comes straight from the input, so the buffer holds
   // one entry fewer than the widest window.
   logic [DW-1:0] buf_r [WM-1];
   logic [3:0]    fill_r;
   logic [3:0]    win_r;
   logic [DW-1:0] pick;
   logic [DW-1:0] out_r;
   logic          valid_r;
   logic          def_r;

   ////////////////////////////////////////////////////////////////////////
   // Newest result enters at index 0; a window change restarts filling.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < WM - 1; i++) begin
            buf_r[i] <= '0;
         end
      end else if (mif.in_valid) begin
         buf_r[0] <= mif.in_data;
         for (int i = 1; i < WM - 1; i++) begin
            buf_r[i] <= buf_r[i-1];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         win_r  <= 4'h1;
         fill_r <= 4'h0;
      end else begin
         win_r <= mif.win_n;
         if (mif.win_n != win_r) begin
            fill_r <= 4'h0;
         end else if (mif.in_valid && fill_r < win_r) begin
            fill_r <= fill_r + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Rank select over the window; ties are broken by position so that
   // exactly one entry holds the middle rank.
   always_comb begin
      logic [DW-1:0] cand [WM];
      logic [3:0]    rank;
      pick    = mif.in_data;
      rank    = 4'h0;
      cand[0] = mif.in_data;
      for (int i = 1; i < WM; i++) begin
         cand[i] = buf_r[i-1];
      end
      for (int i = 0; i < WM; i++) begin
         rank = 4'h0;
         for (int j = 0; j < WM; j++) begin
            if (j < int'(win_r) && (cand[j] < cand[i] ||
                (cand[j] == cand[i] && j < i))) begin
               rank = rank + 4'h1;
            end
         end
         if (i < int'(win_r) && rank == (win_r >> 1)) begin
            pick = cand[i];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_r   <= '0;
         valid_r <= 1'b0;
         def_r   <= 1'b0;
      end else begin
         valid_r <= mif.in_valid;
         if (mif.in_valid) begin
            // Before the window fills the newest result is shown as is.
            if (win_r == 4'h1 || fill_r >= win_r - 4'h1) begin
               out_r <= pick;
               def_r <= 1'b1;
            end else begin
               out_r <= mif.in_data;
               def_r <= 1'b0;
            end
         end
      end
   end

   assign mif.out_valid    = valid_r;
   assign mif.out_data     = out_r;
   assign mif.out_definite = def_r;

   out_follows_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      mif.in_valid |=> mif.out_valid) else $error("no output");
   indef_flag_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (mif.in_valid && win_r > 4'h1 && fill_r < win_r - 4'h1 &&
       mif.win_n == win_r) |=> !mif.out_definite)
      else $error("early output marked definite");
   bypass_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (mif.in_valid && win_r == 4'h1) |=>
      (mif.out_data == $past(mif.in_data) && mif.out_definite))
      else $error("bypass altered data");
   restart_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (mif.win_n != win_r) |=> fill_r == 4'h0)
      else $error("fill not restarted");
   full_def_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (mif.in_valid && fill_r == win_r && mif.win_n == win_r) |=>
      mif.out_definite) else $error("full window not definite");
endmodule

//--- detector_model.sv
`timescale 1ns/100ps
module detector_model (
   input  wire logic        mclk_i,
   input  wire logic        arst_n_i,
   input  wire logic        emitter_on_i,
   input  wire logic [15:0] level_i,
   output logic             det_valid_o,
   output logic [15:0]      det_sample_o
);
   logic emit_r;

   // One reading per pulse, taken as the emitter goes dark. Between readings
   // the sample bus toggles, so a stale value never passes for a fresh one.
   always_ff @(negedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         emit_r       <= 1'b0;
         det_valid_o  <= 1'b0;
         det_sample_o <= 16'h0000;
      end else begin
         emit_r       <= emitter_on_i;
         det_valid_o  <= emit_r & ~emitter_on_i;
         det_sample_o <= (emit_r & ~emitter_on_i) ? level_i : ~det_sample_o;
      end
   end
endmodule

//--- distance_measure_sequencer_test.sv
`timescale 1ns/100ps
module distance_measure_sequencer_test;
   localparam int US   = dms_pkg::US_CYC;
   localparam int SLOT = 330;
   logic        mclk_i;
   logic        arst_n_i;
   logic [2:0]  cap_sel;
   logic [1:0]  accum_sel;
   logic [1:0]  median_sel;
   logic        bench_drv;
   logic        b_valid;
   logic [15:0] b_sample;
   logic        p_valid;
   logic [15:0] p_sample;
   logic [15:0] level;
   logic        dist_valid;
   logic [9:0]  dist_in;
   logic        emitter_on;
   logic        acc_valid;
   logic [20:0] acc_sum;
   logic        dv_out;
   logic [9:0]  d_out;
   logic        d_def;
   int          failures;
   int          n_checks;
   logic [8:0]  caps[5] = '{dms_pkg::CAP0_US, dms_pkg::CAP1_US,
      dms_pkg::CAP2_US, dms_pkg::CAP3_US, dms_pkg::CAP4_US};
   logic [1:0]  acc_codes[3] = '{dms_pkg::ACC_1, dms_pkg::ACC_5,
      dms_pkg::ACC_30};
   int          acc_n[3] = '{1, 5, 30};

   ////////////////////////////////////////////////////////////////////////
   // The slot is shortened to keep the run short; it still exceeds the
   // widest cap, so every pulse fits inside its slot.
   distance_measure_sequencer #(.SLOT_US(SLOT)) u_dut (
      .mclk_i          (mclk_i),
      .arst_n_i        (arst_n_i),
      .cap_sel_i       (cap_sel),
      .accum_sel_i     (accum_sel),
      .median_sel_i    (median_sel),
      .det_valid_i     (bench_drv ? b_valid : p_valid),
      .det_sample_i    (bench_drv ? b_sample : p_sample),
      .dist_valid_i    (dist_valid),
      .dist_i          (dist_in),
      .emitter_on_o    (emitter_on),
      .acc_valid_o     (acc_valid),
      .acc_sum_o       (acc_sum),
      .dist_valid_o    (dv_out),
      .dist_o          (d_out),
      .dist_definite_o (d_def)
   );

   detector_model u_det (
      .mclk_i       (mclk_i),
      .arst_n_i     (arst_n_i),
      .emitter_on_i (emitter_on),
      .level_i      (level),
      .det_valid_o  (p_valid),
      .det_sample_o (p_sample)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic chk_cyc(input int got, input int exp);
      chk_val(32'(got), 32'(exp));
   endtask

   task automatic count_level(input logic lvl, output int n);
      n = 0;
      while (emitter_on === lvl && n < 20000) begin
         @(negedge mclk_i);
         n++;
      end
      if (n >= 20000) begin
         failures++;
         summarize();
      end
   endtask

   task automatic wait_rise();
      int n;
      count_level(1'b1, n);
      count_level(1'b0, n);
   endtask

   task automatic acc_run(input int n);
      int exp;
      exp = 0;
      for (int i = 0; i < n; i++) begin
         b_valid  = 1'b1;
         b_sample = 16'h2000 + 16'(i);
         exp += 'h2000 + i;
         @(negedge mclk_i);
      end
      b_valid = 1'b0;
      chk_val(32'(acc_valid), 32'h1);
      chk_val(32'(acc_sum), 32'(exp));
      @(negedge mclk_i);
      chk_val(32'(acc_valid), 32'h0);
   endtask

   task automatic med_step(input logic [9:0] v, input logic [9:0] e,
                           input logic d);
      dist_valid = 1'b1;
      dist_in    = v;
      @(negedge mclk_i);
      chk_val(32'(dv_out), 32'h1);
      chk_val(32'(d_out), 32'(e));
      chk_val(32'(d_def), 32'(d));
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic test_accum();
      acc_run(10);
      for (int k = 0; k < 3; k++) begin
         accum_sel = acc_codes[k];
         repeat (2) @(negedge mclk_i);
         acc_run(acc_n[k]);
      end
      $display("test accum done");
   endtask

   task automatic test_median();
      int w;
      int v[10];
      int q[$];
      med_step(10'h064, 10'h064, 1'b1);
      med_step(10'h2A5, 10'h2A5, 1'b1);
      for (int k = 1; k < 4; k++) begin
         w = 3 + 2 * k;
         dist_valid = 1'b0;
         median_sel = 2'(k);
         repeat (3) @(negedge mclk_i);
         for (int i = 0; i <= w; i++) begin
            v[i] = (i * 389 + w * 53) % 1000;
            if (i < w - 1) begin
               med_step(10'(v[i]), 10'(v[i]), 1'b0);
            end else begin
               q = {};
               for (int j = i - w + 1; j <= i; j++) begin
                  q.push_back(v[j]);
               end
               q.sort();
               med_step(10'(v[i]), 10'(q[w / 2]), 1'b1);
            end
         end
      end
      dist_valid = 1'b0;
      $display("test median done");
   endtask

   task automatic test_emitter();
      int hi;
      int lo;
      bench_drv = 1'b0;
      wait_rise();
      count_level(1'b1, hi);
      chk_cyc(hi, int'(caps[0]) * US);
      // A new cap may miss the pulse of the slot in which it is taken, so
      // one pulse is skipped before measuring.
      for (int c = 1; c < 5; c++) begin
         cap_sel = 3'(c);
         wait_rise();
         wait_rise();
         count_level(1'b1, hi);
         chk_cyc(hi, int'(caps[c]) * US);
      end
      count_level(1'b0, lo);
      chk_cyc(hi + lo, SLOT * US);
      level = 16'hFFFF;
      wait_rise();
      count_level(1'b1, hi);
      chk_cyc(hi, int'(caps[4] - dms_pkg::WIDTH_STEP_US) * US);
      // The strong reading of that pulse lands one edge later and narrows
      // the width once more; one weak reading must then widen it again.
      @(negedge mclk_i);
      bench_drv = 1'b1;
      b_valid   = 1'b1;
      b_sample  = 16'h0000;
      level     = 16'h8000;
      @(negedge mclk_i);
      b_valid   = 1'b0;
      bench_drv = 1'b0;
      wait_rise();
      count_level(1'b1, hi);
      chk_cyc(hi, int'(caps[4] - dms_pkg::WIDTH_STEP_US) * US);
      $display("test emitter done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   initial begin
      arst_n_i   = 1'b0;
      cap_sel    = 3'h0;
      accum_sel  = 2'h0;
      median_sel = 2'h0;
      bench_drv  = 1'b1;
      b_valid    = 1'b0;
      b_sample   = 16'h0000;
      level      = 16'h0000;
      dist_valid = 1'b0;
      dist_in    = 10'h000;
      failures   = 0;
      n_checks   = 0;
      repeat (8) @(negedge mclk_i);
      chk_val(32'({emitter_on, acc_valid, dv_out, d_def}), 32'h0);
      arst_n_i = 1'b1;
      @(negedge mclk_i);
      test_accum();
      test_median();
      test_emitter();
      summarize();
   end
endmodule
